// ==== verilog/ulf_pkg.sv ====
// ulf_pkg: constants and types for the serial line format block
// assumes a 10 MHz core clock and an 8-bit register port with a 3-bit address
package ulf_pkg;
  // register offsets
  localparam logic [2:0] OFS_DATA = 3'h0; // rx/tx buffer or divisor low
  localparam logic [2:0] OFS_IER = 3'h1; // event mask or divisor high
  localparam logic [2:0] OFS_EVT = 3'h2; // event status, write one to clear
  localparam logic [2:0] OFS_LFC = 3'h3; // line format control
  localparam logic [2:0] OFS_LSR = 3'h5; // line status, errors clear on read
  // line format control fields
  localparam int LFC_DLAB = 7;
  localparam int LFC_SIL = 6;
  localparam int LFC_FIXP = 5;
  localparam int LFC_EVEN = 4;
  localparam int LFC_PEN = 3;
  localparam int LFC_XSTOP = 2;
  // event bits, shared by status and mask
  localparam int EV_RX = 0;
  localparam int EV_TXE = 1;
  localparam int EV_ERR = 2;
  localparam int EV_W = 3;
  // reset values
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  // tick counts within one character, at 16 ticks per bit
  localparam logic [5:0] BIT_LAST = 6'h0F;
  localparam logic [5:0] MID_LAST = 6'h07;
  localparam logic [5:0] STOP1_LAST = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST = 6'h1F;
  // fifo geometry
  localparam int FIFO_AW = 4;
  localparam int FIFO_W = 8;
  // divisor for the midi rate of 31250 bit/s
  localparam int CLK_HZ = 10_000_000;
  localparam int MIDI_BAUD = 31_250;
  localparam logic [15:0] MIDI_DIV = 16'(CLK_HZ / (16 * MIDI_BAUD));
  // serial engine states, gray along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PAR = 3'h2,
    ST_STOP = 3'h6
  } ulf_state_e;
endpackage

// ==== verilog/ulf_uart.sv ====
// ulf_uart: serial port with programmable character format and divisor
// assumes synchronous inputs, single-cycle strobes and one 10 MHz clock
//
// Summary of operation
// - A character is start, five to eight data bits, optional parity, then 1, 1.5 or 2 stops.
// - A divisor of 1 to 65535 yields a tick at sixteen times the bit rate for the transmitter.
// - The receiver runs from the same sixteen-times tick.
// - The midi rate is reachable through the divisor.
// - Separate 16-entry byte fifos hold received and pending characters.
// - With the divisor select bit set, offsets 0 and 1 reach the divisor bytes.
// - With it clear, offset 0 reaches the rx/tx buffers and offset 1 the enable register.
// - The silence bit holds the infrared output low without disturbing the transmitter.
// - Fixed parity sends and checks 0 when even is selected and 1 otherwise.
// - Normal parity counts the ones of the data, even or odd as selected.
// - Parity enable inserts and checks a parity bit after the last data bit.
// - The extra-stop bit gives 1.5 stops with 5-bit data and 2 stops otherwise.
// - The two length bits select 5, 6, 7 or 8 data bits.
// - Data bit 0 goes first on the line.
`timescale 1ns/1ps

module ulf_fifo #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem_reg [2**AW];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic do_push;
  logic do_pop;

  // head of queue and occupancy flags
  assign full = cnt_reg[AW];
  assign empty = (cnt_reg == '0);
  assign dout = mem_reg[rd_ptr_reg];
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  // storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= din;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module ulf_uart
  import ulf_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic INFRARED_TX_OUT,
  output logic IRQ
);
  logic [7:0] lfc_reg;
  logic [15:0] div_reg;
  logic [EV_W-1:0] ier_reg;
  logic [EV_W-1:0] evt_reg;
  logic [15:0] baud_cnt_reg;
  logic tick_reg;
  logic dlab;
  logic [1:0] len_sel;
  logic [5:0] stop_last;
  // tx side
  ulf_state_e tx_st_reg;
  logic [5:0] tx_tcnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_sh_reg;
  logic tx_par_reg;
  logic tx_level;
  logic tx_empty_prev_reg;
  logic txf_push;
  logic txf_pop;
  logic [7:0] txf_dout;
  logic txf_full;
  logic txf_empty;
  // rx side
  ulf_state_e rx_st_reg;
  logic [5:0] rx_tcnt_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic rx_prev_reg;
  logic rx_perr_reg;
  logic [7:0] rx_word;
  logic rx_done;
  logic rxf_pop;
  logic [7:0] rxf_dout;
  logic rxf_full;
  logic rxf_empty;
  // line status errors
  logic overrun_reg;
  logic perr_reg;
  logic ferr_reg;
  logic rx_ferr;
  logic [EV_W-1:0] ev_set;
  logic lsr_rd;

  // parity of the active data bits under the current format
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lfc);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - lfc[1:0]);
    if (lfc[LFC_FIXP]) begin
      par_of = ~lfc[LFC_EVEN];
    end else begin
      par_of = lfc[LFC_EVEN] ? ^(d & m) : ~^(d & m);
    end
  endfunction

  // format decode
  assign dlab = lfc_reg[LFC_DLAB];
  assign len_sel = lfc_reg[1:0];
  always_comb begin
    if (!lfc_reg[LFC_XSTOP]) begin
      stop_last = STOP1_LAST;
    end else if (len_sel == 2'h0) begin
      stop_last = STOP15_LAST;
    end else begin
      stop_last = STOP2_LAST;
    end
  end

  // bus decode side effects
  assign txf_push = WR_STB && (ADDR == OFS_DATA) && !dlab;
  assign rxf_pop = RD_STB && (ADDR == OFS_DATA) && !dlab;
  assign lsr_rd = RD_STB && (ADDR == OFS_LSR);

  // transmit and receive fifos
  ulf_fifo #(.W(FIFO_W), .AW(FIFO_AW)) u_txf (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .push(txf_push),
    .din(WR_DATA),
    .pop(txf_pop),
    .dout(txf_dout),
    .full(txf_full),
    .empty(txf_empty)
  );
  ulf_fifo #(.W(FIFO_W), .AW(FIFO_AW)) u_rxf (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .push(rx_done),
    .din(rx_word),
    .pop(rxf_pop),
    .dout(rxf_dout),
    .full(rxf_full),
    .empty(rxf_empty)
  );

  // register writes: format, divisor, mask
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      lfc_reg <= LFC_RST;
      div_reg <= DIV_RST;
      ier_reg <= EV_RST;
    end else if (WR_STB) begin
      case (ADDR)
        OFS_LFC: lfc_reg <= WR_DATA;
        OFS_DATA: begin
          if (dlab) begin
            div_reg[7:0] <= WR_DATA;
          end
        end
        OFS_IER: begin
          if (dlab) begin
            div_reg[15:8] <= WR_DATA;
          end else begin
            ier_reg <= WR_DATA[EV_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // sixteen-times tick; divisor 0 stops the tick
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      baud_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == '0) begin
      baud_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (baud_cnt_reg >= div_reg - 16'h0001) begin
      baud_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // transmitter pops the fifo only when idle on a tick
  assign txf_pop = tick_reg && (tx_st_reg == ST_IDLE) && !txf_empty;

  // transmit sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      tx_st_reg <= ST_IDLE;
      tx_tcnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '0;
      tx_par_reg <= 1'b0;
    end else if (tick_reg) begin
      tx_tcnt_reg <= tx_tcnt_reg + 6'h01;
      case (tx_st_reg)
        ST_IDLE: begin
          tx_tcnt_reg <= '0;
          if (!txf_empty) begin
            tx_sh_reg <= txf_dout;
            tx_par_reg <= par_of(txf_dout, lfc_reg);
            tx_bit_reg <= '0;
            tx_st_reg <= ST_START;
          end
        end
        ST_START: begin
          if (tx_tcnt_reg == BIT_LAST) begin
            tx_tcnt_reg <= '0;
            tx_st_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_tcnt_reg == BIT_LAST) begin
            tx_tcnt_reg <= '0;
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == {1'b1, len_sel}) begin
              tx_st_reg <= lfc_reg[LFC_PEN] ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tx_tcnt_reg == BIT_LAST) begin
            tx_tcnt_reg <= '0;
            tx_st_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_tcnt_reg == stop_last) begin
            tx_tcnt_reg <= '0;
            tx_st_reg <= ST_IDLE;
          end
        end
        default: tx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // line level for the current transmit state
  always_comb begin
    case (tx_st_reg)
      ST_START: tx_level = 1'b0;
      ST_DATA: tx_level = tx_sh_reg[0];
      ST_PAR: tx_level = tx_par_reg;
      default: tx_level = 1'b1;
    endcase
  end

  // registered pins; silence touches only the infrared path
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      SERIAL_OUT <= 1'b1;
      INFRARED_TX_OUT <= 1'b1;
    end else begin
      SERIAL_OUT <= tx_level;
      INFRARED_TX_OUT <= tx_level & ~lfc_reg[LFC_SIL];
    end
  end

  // received word right-aligned to the character length
  assign rx_word = rx_sh_reg >> (2'h3 - len_sel);
  assign rx_done = tick_reg && (rx_st_reg == ST_STOP) && (rx_tcnt_reg == BIT_LAST);
  assign rx_ferr = !SERIAL_IN;

  // receive sequencer; after the start check every sample is mid-cell
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rx_st_reg <= ST_IDLE;
      rx_tcnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_prev_reg <= 1'b1;
      rx_perr_reg <= 1'b0;
    end else begin
      rx_prev_reg <= SERIAL_IN;
      case (rx_st_reg)
        ST_IDLE: begin
          rx_tcnt_reg <= '0;
          rx_bit_reg <= '0;
          rx_perr_reg <= 1'b0;
          if (rx_prev_reg && !SERIAL_IN) begin
            rx_st_reg <= ST_START;
          end
        end
        ST_START: begin
          if (tick_reg) begin
            rx_tcnt_reg <= rx_tcnt_reg + 6'h01;
            if (rx_tcnt_reg == MID_LAST) begin
              rx_tcnt_reg <= '0;
              rx_st_reg <= SERIAL_IN ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick_reg) begin
            rx_tcnt_reg <= rx_tcnt_reg + 6'h01;
            if (rx_tcnt_reg == BIT_LAST) begin
              rx_tcnt_reg <= '0;
              rx_sh_reg <= {SERIAL_IN, rx_sh_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == {1'b1, len_sel}) begin
                rx_st_reg <= lfc_reg[LFC_PEN] ? ST_PAR : ST_STOP;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick_reg) begin
            rx_tcnt_reg <= rx_tcnt_reg + 6'h01;
            if (rx_tcnt_reg == BIT_LAST) begin
              rx_tcnt_reg <= '0;
              rx_perr_reg <= SERIAL_IN ^ par_of(rx_word, lfc_reg);
              rx_st_reg <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          // first stop checked mid-cell; the rest is idle time to the receiver
          if (tick_reg) begin
            rx_tcnt_reg <= rx_tcnt_reg + 6'h01;
            if (rx_tcnt_reg == BIT_LAST) begin
              rx_st_reg <= ST_IDLE;
            end
          end
        end
        default: rx_st_reg <= ST_IDLE;
      endcase
    end
  end

  // line status errors, sticky until status read; a new error wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      overrun_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      overrun_reg <= (rx_done && rxf_full) || (overrun_reg && !lsr_rd);
      perr_reg <= (rx_done && rx_perr_reg) || (perr_reg && !lsr_rd);
      ferr_reg <= (rx_done && rx_ferr) || (ferr_reg && !lsr_rd);
    end
  end

  // event sources
  assign ev_set[EV_RX] = rx_done && !rxf_full;
  assign ev_set[EV_TXE] = txf_empty && !tx_empty_prev_reg;
  assign ev_set[EV_ERR] = rx_done && (rxf_full || rx_perr_reg || rx_ferr);

  // sticky event status, write one to clear, set wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      evt_reg <= EV_RST;
      tx_empty_prev_reg <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      tx_empty_prev_reg <= txf_empty;
      if (WR_STB && (ADDR == OFS_EVT)) begin
        evt_reg <= (evt_reg & ~WR_DATA[EV_W-1:0]) | ev_set;
      end else begin
        evt_reg <= evt_reg | ev_set;
      end
      IRQ <= |(evt_reg & ier_reg);
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      RD_DATA <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        OFS_DATA: RD_DATA <= dlab ? div_reg[7:0] : rxf_dout;
        OFS_IER: RD_DATA <= dlab ? div_reg[15:8] : {5'h00, ier_reg};
        OFS_EVT: RD_DATA <= {5'h00, evt_reg};
        OFS_LFC: RD_DATA <= lfc_reg;
        OFS_LSR: RD_DATA <= {1'b0, (tx_st_reg == ST_IDLE) && txf_empty, txf_empty,
                             1'b0, ferr_reg, perr_reg, overrun_reg, !rxf_empty};
        default: RD_DATA <= 8'h00;
      endcase
    end else begin
      RD_DATA <= 8'h00;
    end
  end
endmodule

// ==== bench/ulf_remote.sv ====
// ulf_remote: far-side serial device, sends and receives whole characters
// assumes divisor 1 (16 clocks per bit) and format bits mirrored on fmt
`timescale 1ns/1ps

module ulf_remote #(
  parameter int BITC = 16
) (
  input wire logic clk,
  input wire logic line_in,
  input wire logic [7:0] fmt,
  output logic line_out,
  output logic [9:0] got,
  output logic got_v,
  output int got_n
);
  logic [7:0] v;
  logic p;
  int rn;

  // parity bit for a character, 0 when parity is off
  function automatic logic par(logic [7:0] d, logic [7:0] f);
    logic [7:0] m;
    m = 8'hFF >> (3 - f[1:0]);
    if (!f[3]) return 1'b0;
    if (f[5]) return !f[4];
    return f[4] ? ^(d & m) : ~^(d & m);
  endfunction

  // idle line rests high
  initial begin
    line_out = 1'b1;
    got_v = 1'b0;
    got_n = 0;
    got = '0;
  end

  // receive: confirm start mid-cell, then lsb first, parity, first stop
  initial forever begin
    @(negedge line_in);
    repeat (BITC / 2) @(posedge clk);
    if (!line_in) begin
      rn = 5 + fmt[1:0];
      v = '0;
      for (int k = 0; k < rn; k++) begin
        repeat (BITC) @(posedge clk);
        v[k] = line_in;
      end
      p = 1'b0;
      if (fmt[3]) begin
        repeat (BITC) @(posedge clk);
        p = line_in;
      end
      repeat (BITC) @(posedge clk);
      got <= {line_in, p, v};
      got_v <= 1'b1;
      got_n <= got_n + 1;
      @(posedge clk);
      got_v <= 1'b0;
    end
  end

  // send one character after gap idle bit times
  task automatic send(input logic [7:0] d, input int gap);
    int nd;
    nd = 5 + fmt[1:0];
    repeat (gap * BITC) @(posedge clk);
    line_out <= 1'b0;
    repeat (BITC) @(posedge clk);
    for (int k = 0; k < nd; k++) begin
      line_out <= d[k];
      repeat (BITC) @(posedge clk);
    end
    if (fmt[3]) begin
      line_out <= par(d, fmt);
      repeat (BITC) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat ((fmt[2] ? (nd == 5 ? 3 : 4) : 2) * BITC / 2) @(posedge clk);
  endtask
endmodule

// ==== bench/ulf_uart_monitor.sv ====
// ulf_uart_monitor: port-level checks of register access and line output
// assumes divisor changes only while the line is idle
`timescale 1ns/1ps

module ulf_uart_monitor
  import ulf_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic SERIAL_IN,
  input wire logic SERIAL_OUT,
  input wire logic INFRARED_TX_OUT,
  input wire logic IRQ
);
  logic [7:0] lfc, lq;
  logic [15:0] dv, dq;
  int lowc;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // shadow copies of format and divisor, plus a delayed copy
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) lfc <= LFC_RST;
    else if (WR_STB && ADDR == OFS_LFC) lfc <= WR_DATA;
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) dv <= DIV_RST;
    else if (WR_STB && lfc[LFC_DLAB] && ADDR == OFS_DATA) dv[7:0] <= WR_DATA;
    else if (WR_STB && lfc[LFC_DLAB] && ADDR == OFS_IER) dv[15:8] <= WR_DATA;
  end
  always_ff @(posedge CORE_CLK) begin
    lq <= lfc;
    dq <= dv;
  end
  // length of the current low run on the line
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN || SERIAL_OUT) lowc <= 0;
    else lowc <= lowc + 1;
  end

  rd_idle_a: assert property (!RD_STB |=> RD_DATA == 8'h00)
    else $error("read data not zero outside a read");
  fmt_read_a: assert property (RD_STB && ADDR == OFS_LFC |=> RD_DATA == lq)
    else $error("format read mismatch");
  div_low_a: assert property (RD_STB && ADDR == OFS_DATA && lfc[LFC_DLAB] |=> RD_DATA == dq[7:0])
    else $error("divisor low read mismatch");
  div_high_a: assert property (RD_STB && ADDR == OFS_IER && lfc[LFC_DLAB] |=> RD_DATA == dq[15:8])
    else $error("divisor high read mismatch");
  mask_read_a: assert property (RD_STB && ADDR == OFS_IER && !lfc[LFC_DLAB] |=> RD_DATA[7:3] == 5'h00)
    else $error("mask read has stray bits");
  ir_silent_a: assert property (lfc[LFC_SIL] && $past(lfc[LFC_SIL]) |-> !INFRARED_TX_OUT)
    else $error("infrared output not silenced");
  ir_follow_a: assert property (!lfc[LFC_SIL] && !$past(lfc[LFC_SIL]) |-> INFRARED_TX_OUT == SERIAL_OUT)
    else $error("infrared output differs from line");
  low_run_a: assert property ($rose(SERIAL_OUT) |-> lowc % (16 * int'(dv)) == 0)
    else $error("low run not whole bits");
  low_max_a: assert property (!SERIAL_OUT |-> lowc < 160 * int'(dv))
    else $error("line low too long");
endmodule

bind ulf_uart ulf_uart_monitor ulf_uart_monitor_i (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
  .INFRARED_TX_OUT(INFRARED_TX_OUT), .IRQ(IRQ)
);

// ==== bench/ulf_uart_tb.sv ====
// ulf_uart_tb: register access, format sweep both ways, interrupts, silence
// assumes divisor 1, so one bit is 16 clocks of 100 ns
`timescale 1ns/1ps

module ulf_uart_tb
  import ulf_pkg::*;
;
  logic CORE_CLK, RESETN, WR_STB, RD_STB, SERIAL_IN, SERIAL_OUT, INFRARED_TX_OUT, IRQ;
  logic [2:0] ADDR;
  logic [7:0] WR_DATA, RD_DATA, fmt, lf, td, rx, m;
  logic [9:0] got;
  logic got_v, rd_pend;
  int got_n, fail_count, n_compared, n;
  logic [15:0] rq[$];
  logic [9:0] sq[$];
  localparam logic [7:0] FM [8] = '{8'h00, 8'h04, 8'h09, 8'h0D, 8'h1A, 8'h2B, 8'h3F, 8'h1B};

  ulf_uart ulf_uart_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SERIAL_IN(SERIAL_IN),
    .SERIAL_OUT(SERIAL_OUT), .INFRARED_TX_OUT(INFRARED_TX_OUT), .IRQ(IRQ));
  ulf_remote #(.BITC(16)) ulf_remote_i (.clk(CORE_CLK), .line_in(SERIAL_OUT), .fmt(fmt),
    .line_out(SERIAL_IN), .got(got), .got_v(got_v), .got_n(got_n));

  // 10 MHz clock
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  function automatic logic [7:0] nx(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // bus cycles: one strobe cycle each, strobes dropped by idle
  task wr(input logic [2:0] a, input logic [7:0] d);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    RD_STB <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    ADDR <= a;
    RD_STB <= 1'b1;
    WR_STB <= 1'b0;
    rq.push_back(16'(e));
    @(posedge CORE_CLK);
  endtask
  task idle(input int c);
    WR_STB <= 1'b0;
    RD_STB <= 1'b0;
    repeat (c) @(posedge CORE_CLK);
  endtask
  task wait_n(input int t);
    for (int k = 0; k < 5000 && got_n < t; k++) @(posedge CORE_CLK);
    if (got_n < t) begin
      fail_count++;
      finish_test();
    end
  endtask

  // watcher: read data one cycle after the strobe, characters from the far side
  always @(posedge CORE_CLK) begin
    rd_pend <= RD_STB;
    if (rd_pend === 1'b1) chk(16'(RD_DATA), rq.pop_front());
    if (got_v === 1'b1) chk(16'(got), 16'(sq.pop_front()));
  end

  initial begin
    {ADDR, WR_DATA, WR_STB, RD_STB, fmt} = '0;
    RESETN = 1'b0;
    lf = 8'h01;
    repeat (6) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    rd(OFS_LFC, LFC_RST);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    idle(2);
    $display("done: reset and unmapped");
    // divisor bytes behind the select bit, midi rate then back to 1
    wr(OFS_LFC, 8'h83);
    wr(OFS_DATA, MIDI_DIV[7:0]);
    wr(OFS_IER, MIDI_DIV[15:8]);
    rd(OFS_DATA, MIDI_DIV[7:0]);
    rd(OFS_IER, MIDI_DIV[15:8]);
    wr(OFS_DATA, 8'h01);
    wr(OFS_IER, 8'h00);
    wr(OFS_LFC, 8'h03);
    rd(OFS_IER, 8'h00);
    idle(2);
    $display("done: divisor access");
    // every length, parity mode and stop setting, both directions at once
    for (int i = 0; i < 8; i++) begin
      fmt <= FM[i];
      wr(OFS_LFC, FM[i]);
      lf = nx(lf);
      td = lf;
      lf = nx(lf);
      rx = lf;
      m = 8'hFF >> (3 - FM[i][1:0]);
      sq.push_back({1'b1, ulf_remote_i.par(td, FM[i]), td & m});
      wr(OFS_DATA, td);
      idle(1);
      n = got_n;
      ulf_remote_i.send(rx, i % 2);
      wait_n(n + 1);
      rd(OFS_DATA, rx & m);
      idle(1);
    end
    $display("done: format sweep");
    // silence holds the infrared output low, the line still carries data
    fmt <= 8'h43;
    wr(OFS_LFC, 8'h43);
    sq.push_back({2'b10, 8'hA5});
    wr(OFS_DATA, 8'hA5);
    n = got_n;
    idle(40);
    chk(16'(INFRARED_TX_OUT), 16'h0000);
    wait_n(n + 1);
    wr(OFS_LFC, 8'h03);
    idle(2);
    $display("done: silence");
    // interrupt: masked, unmasked, cleared
    wr(OFS_IER, 8'h00);
    idle(3);
    chk(16'(IRQ), 16'h0000);
    wr(OFS_IER, 8'h01);
    idle(3);
    chk(16'(IRQ), 16'h0001);
    rd(OFS_EVT, 8'h03);
    wr(OFS_EVT, 8'h07);
    idle(3);
    chk(16'(IRQ), 16'h0000);
    rd(OFS_EVT, 8'h00);
    idle(3);
    $display("done: interrupt");
    // far side sends odd parity while even is expected: parity error flagged
    fmt <= 8'h0B;
    wr(OFS_LFC, 8'h1B);
    idle(1);
    ulf_remote_i.send(8'h3C, 0);
    rd(OFS_DATA, 8'h3C);
    rd(OFS_LSR, 8'h64);
    rd(OFS_LSR, 8'h60);
    rd(OFS_EVT, 8'h05);
    idle(2);
    $display("done: parity error");
    finish_test();
  end
endmodule
